// *** logic/gpihb_pkg.sv ***
// package: selectors, field layout, reset values and carriers for gpihb
package gpihb_pkg;
   localparam int unsigned DATA_W   = 32;
   localparam int unsigned PN_W     = 5;
   localparam int unsigned SEL_W    = 3;
   // register selectors on the system-register load port
   localparam logic [2:0] SEL_GPN   = 3'h0; // guest protection number
   localparam logic [2:0] SEL_GLIST = 3'h1; // guest allowed number list
   localparam logic [2:0] SEL_GBASE = 3'h2; // guest handler base
   localparam logic [2:0] SEL_PN    = 3'h3; // protection number (mapped)
   localparam logic [2:0] SEL_LIST  = 3'h4; // host list (mapped)
   // field positions
   localparam int unsigned PN_LSB   = 0;
   localparam int unsigned PN_MSB   = 4;
   localparam int unsigned BASE_LSB = 9;
   localparam int unsigned BASE_MSB = 31;
   localparam int unsigned DV_BIT   = 1;
   localparam int unsigned RH_BIT   = 0;
   // reset values (the hardware leaves them implementation defined)
   localparam logic [4:0]  PN_RST    = 5'h00;
   localparam logic [31:0] LIST_RST  = 32'h0000_0000;
   localparam logic [22:0] BASE_RST  = 23'h00_0000;
   localparam logic        DV_RST    = 1'b0;
   localparam logic        RH_RST    = 1'b0;
   localparam logic [31:0] ZERO_W    = 32'h0000_0000;

   typedef struct packed {
      logic        wr;     // write strobe
      logic        rd;     // read strobe
      logic        multi;  // from the multiple-register load instruction
      logic [2:0]  sel;    // register selector
      logic [31:0] wdata;  // write data
   } gpihb_req_s;

   typedef struct packed {
      logic        valid;      // handler address wanted
      logic        maskable_interrupt_request;      // maskable interrupt request
      logic        req_table;  // request asks for the table method
      logic [31:0] offset;     // unreduced offset
      logic [31:0] red_offset; // reduced offset
   } gpihb_hreq_s;
endpackage

// *** logic/gpihb_top.sv ***
// guest protection number, allowed-number list and handler base registers
`timescale 1ns/1ps
// Behaviour
// - Bits 4 to 0 hold the guest identifier, also used for MPU matching.
// - Number bits 31 to 5 and handler base bits 8 to 2 read as zero.
// - A write of a number not permitted is ignored; the old value stays.
// - Direct writes ignore the lock; guest mapped-path writes obey it.
// - Single and multiple load direct writes are filtered by the host list.
// - Direct writes to the guest number ignore the guest list.
// - A guest-mode mapped number write is filtered by the guest list.
// - In guest mode accesses to the mapped list go to the guest list.
// - Bit n of the guest list says whether number n may be loaded.
// - The guest list is written only in host mode.
// - A host write sets a guest list bit only where the host bit is one.
// - In guest mode the base-select bit reads one; the guest base applies.
// - The handler address is the base of bits 31 to 9 plus the offset.
// - Vector select clear uses an interrupt's requested method; set, or an exception, forces vectors.
// - With vectors, a set reduced select bit picks the reduced address for interrupts.
module gpihb_top #(
   parameter logic [4:0]  PN_RESET   = gpihb_pkg::PN_RST,
   parameter logic [31:0] LIST_RESET = gpihb_pkg::LIST_RST
) (
   input  wire logic                    core_clk,        // core clock
   input  wire logic                    rst,             // sync reset
   input  wire logic                    guest_mode,      // core in guest mode
   input  wire logic                    supervisor_lock_bit, // lock set
   input  wire logic [31:0]             host_allowed_number_list, // host
   input  wire gpihb_pkg::gpihb_req_s   req,             // register access
   input  wire gpihb_pkg::gpihb_hreq_s  hreq,            // handler request
   output logic [31:0]                  rdata,           // read data
   output logic                         rd_valid,        // read data valid
   output logic                         wr_refused,      // write ignored
   output logic [4:0]                   guest_pn_out,    // current number
   output logic                         guest_base_select_bit, // base sel
   output logic                         hrsp_valid,      // address ready
   output logic [31:0]                  hrsp_addr,       // handler address
   output logic                         hrsp_table       // table method
);
   import gpihb_pkg::*;

   logic [4:0]  pn_r;
   logic [31:0] glist_r;
   logic [22:0] base_r;
   logic        dv_r;
   logic        rh_r;
   logic [31:0] rdata_r;
   logic        rd_valid_r;
   logic        wr_refused_r;
   logic        base_sel_r;
   logic        hrsp_valid_r;
   logic [31:0] hrsp_addr_r;
   logic        hrsp_table_r;

   logic [4:0]  wr_pn;
   logic        pn_direct;
   logic        pn_mapped;
   logic        pn_ok;
   logic        pn_wr_ok;
   logic        list_sel;
   logic        list_wr_ok;
   logic        base_wr;
   logic        refuse;
   logic [31:0] base_addr;
   logic        use_vector;
   logic [31:0] pn_nxt;
   logic [31:0] rd_nxt;

   assign wr_pn      = req.wdata[PN_MSB:PN_LSB];
   // direct path: host list only, lock ignored
   assign pn_direct  = req.wr && (req.sel == SEL_GPN);
   // mapped path: only in guest mode is it this block's register
   assign pn_mapped  = req.wr && (req.sel == SEL_PN) && guest_mode;
   assign list_sel   = (req.sel == SEL_GLIST)
                       || ((req.sel == SEL_LIST) && guest_mode);
   assign base_wr    = req.wr && (req.sel == SEL_GBASE);

   always_comb begin
      pn_ok = 1'b0;
      if (pn_direct) begin
         pn_ok = host_allowed_number_list[wr_pn];
      end else if (pn_mapped) begin
         pn_ok = glist_r[wr_pn] && !supervisor_lock_bit;
      end
   end

   assign pn_wr_ok   = (pn_direct || pn_mapped) && pn_ok;
   assign list_wr_ok = req.wr && list_sel && !guest_mode;
   assign refuse     = ((pn_direct || pn_mapped) && !pn_ok)
                       || (req.wr && list_sel && guest_mode);

   // protection number
   always_ff @(posedge core_clk) begin
      if (rst) begin
         pn_r <= PN_RESET;
      end else if (pn_wr_ok) begin
         pn_r <= wr_pn;
      end
   end

   // guest list, each bit capped by the host list
   always_ff @(posedge core_clk) begin
      if (rst) begin
         glist_r <= LIST_RESET;
      end else if (list_wr_ok) begin
         glist_r <= req.wdata & host_allowed_number_list;
      end
   end

   // handler base, direct-vector and reduced-handler bits
   always_ff @(posedge core_clk) begin
      if (rst) begin
         base_r <= BASE_RST;
         dv_r   <= DV_RST;
         rh_r   <= RH_RST;
      end else if (base_wr) begin
         base_r <= req.wdata[BASE_MSB:BASE_LSB];
         dv_r   <= req.wdata[DV_BIT];
         rh_r   <= req.wdata[RH_BIT];
      end
   end

   // guest status word base-select bit never leaves one in guest mode
   always_ff @(posedge core_clk) begin
      if (rst) begin
         base_sel_r <= 1'b1;
      end else begin
         base_sel_r <= 1'b1;
      end
   end

   assign pn_nxt = {27'h000_0000, pn_r};

   // read mux, reserved bits forced to zero
   always_comb begin
      rd_nxt = ZERO_W;
      if (req.sel == SEL_GPN) begin
         rd_nxt = pn_nxt;
      end else if (list_sel) begin
         rd_nxt = glist_r;
      end else if (req.sel == SEL_GBASE) begin
         rd_nxt = {base_r, 7'h00, dv_r, rh_r};
      end else if ((req.sel == SEL_PN) && guest_mode) begin
         rd_nxt = pn_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         rdata_r    <= ZERO_W;
         rd_valid_r <= 1'b0;
      end else begin
         rd_valid_r <= req.rd;
         if (req.rd) begin
            rdata_r <= rd_nxt;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         wr_refused_r <= 1'b0;
      end else begin
         wr_refused_r <= refuse;
      end
   end

   // handler address: table method returns no address, the caller
   // fetches through the table base which lives outside this block
   assign base_addr  = {base_r, 9'h000};
   assign use_vector = !hreq.maskable_interrupt_request || dv_r || !hreq.req_table;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         hrsp_valid_r <= 1'b0;
         hrsp_addr_r  <= ZERO_W;
         hrsp_table_r <= 1'b0;
      end else begin
         hrsp_valid_r <= hreq.valid;
         if (hreq.valid) begin
            hrsp_table_r <= !use_vector;
            if (!use_vector) begin
               hrsp_addr_r <= ZERO_W;
            end else if (hreq.maskable_interrupt_request && rh_r) begin
               hrsp_addr_r <= base_addr + hreq.red_offset;
            end else begin
               hrsp_addr_r <= base_addr + hreq.offset;
            end
         end
      end
   end

   assign rdata                 = rdata_r;
   assign rd_valid              = rd_valid_r;
   assign wr_refused            = wr_refused_r;
   assign guest_pn_out          = pn_r;
   assign guest_base_select_bit = base_sel_r;
   assign hrsp_valid            = hrsp_valid_r;
   assign hrsp_addr             = hrsp_addr_r;
   assign hrsp_table            = hrsp_table_r;

   // checks
   property p_pn_direct_ok;
      @(posedge core_clk) disable iff (rst)
      (req.wr && req.sel == SEL_GPN
       && host_allowed_number_list[req.wdata[4:0]])
      |=> (guest_pn_out == $past(req.wdata[4:0]));
   endproperty
   a_pn_direct_ok: assert property (p_pn_direct_ok)
      else $error("permitted direct write not stored");

   property p_pn_refused;
      @(posedge core_clk) disable iff (rst)
      (req.wr && req.sel == SEL_GPN
       && !host_allowed_number_list[req.wdata[4:0]])
      |=> ($stable(guest_pn_out) && wr_refused);
   endproperty
   a_pn_refused: assert property (p_pn_refused)
      else $error("refused number changed the register");

   property p_pn_lock;
      @(posedge core_clk) disable iff (rst)
      (req.wr && req.sel == SEL_PN && guest_mode && supervisor_lock_bit)
      |=> $stable(guest_pn_out);
   endproperty
   a_pn_lock: assert property (p_pn_lock)
      else $error("locked mapped write changed the number");

   property p_pn_guest_list;
      @(posedge core_clk) disable iff (rst)
      (req.wr && req.sel == SEL_PN && guest_mode && !supervisor_lock_bit)
      |=> (guest_pn_out == ($past(glist_r[req.wdata[4:0]])
           ? $past(req.wdata[4:0]) : $past(guest_pn_out)));
   endproperty
   a_pn_guest_list: assert property (p_pn_guest_list)
      else $error("mapped write not filtered by guest list");

   property p_list_guest_block;
      @(posedge core_clk) disable iff (rst)
      (req.wr && guest_mode
       && (req.sel == SEL_GLIST || req.sel == SEL_LIST))
      |=> $stable(glist_r);
   endproperty
   a_list_guest_block: assert property (p_list_guest_block)
      else $error("guest mode wrote the guest list");

   property p_list_mask;
      @(posedge core_clk) disable iff (rst)
      (req.wr && !guest_mode && req.sel == SEL_GLIST)
      |=> (glist_r == ($past(req.wdata)
           & $past(host_allowed_number_list)));
   endproperty
   a_list_mask: assert property (p_list_mask)
      else $error("guest list not capped by host list");

   property p_read_reserved;
      @(posedge core_clk) disable iff (rst)
      (req.rd && (req.sel == SEL_GPN || req.sel == SEL_GBASE))
      |=> (rd_valid && (($past(req.sel) == SEL_GBASE)
           ? (rdata[8:2] == 7'h00) : (rdata[31:5] == 27'h000_0000)));
   endproperty
   a_read_reserved: assert property (p_read_reserved)
      else $error("reserved bits read non-zero");

   property p_list_redirect;
      @(posedge core_clk) disable iff (rst)
      (req.rd && guest_mode && req.sel == SEL_LIST)
      |=> (rd_valid && rdata == $past(glist_r));
   endproperty
   a_list_redirect: assert property (p_list_redirect)
      else $error("mapped list read not redirected");

   property p_base_sel;
      @(posedge core_clk) disable iff (rst)
      guest_mode |-> guest_base_select_bit;
   endproperty
   a_base_sel: assert property (p_base_sel)
      else $error("base select bit low in guest mode");

   property p_vector_forced;
      @(posedge core_clk) disable iff (rst)
      (hreq.valid && hreq.maskable_interrupt_request && dv_r && !rh_r)
      |=> (hrsp_valid && !hrsp_table
           && hrsp_addr == ({$past(base_r), 9'h000} + $past(hreq.offset)));
   endproperty
   a_vector_forced: assert property (p_vector_forced)
      else $error("direct vector select not honoured");

   property p_reduced;
      @(posedge core_clk) disable iff (rst)
      (hreq.valid && hreq.maskable_interrupt_request && rh_r && (dv_r || !hreq.req_table))
      |=> (hrsp_addr == ({$past(base_r), 9'h000}
           + $past(hreq.red_offset)));
   endproperty
   a_reduced: assert property (p_reduced)
      else $error("reduced handler address not used");

   property p_table;
      @(posedge core_clk) disable iff (rst)
      (hreq.valid && hreq.maskable_interrupt_request && !dv_r && hreq.req_table)
      |=> (hrsp_valid && hrsp_table);
   endproperty
   a_table: assert property (p_table)
      else $error("request method ignored with vector select clear");

   property p_exc_addr;
      @(posedge core_clk) disable iff (rst)
      (hreq.valid && !hreq.maskable_interrupt_request)
      |=> (hrsp_valid && !hrsp_table
           && hrsp_addr == ({$past(base_r), 9'h000} + $past(hreq.offset)));
   endproperty
   a_exc_addr: assert property (p_exc_addr)
      else $error("exception handler address wrong");

   property p_direct_guest_free;
      @(posedge core_clk) disable iff (rst)
      (req.wr && req.sel == SEL_GPN && guest_mode
       && host_allowed_number_list[req.wdata[4:0]]
       && !glist_r[req.wdata[4:0]])
      |=> (guest_pn_out == $past(req.wdata[4:0]));
   endproperty
   a_direct_guest_free: assert property (p_direct_guest_free)
      else $error("direct write checked against guest list");

   property p_direct_lock_free;
      @(posedge core_clk) disable iff (rst)
      (req.wr && req.sel == SEL_GPN && supervisor_lock_bit
       && host_allowed_number_list[req.wdata[4:0]])
      |=> !wr_refused;
   endproperty
   a_direct_lock_free: assert property (p_direct_lock_free)
      else $error("supervisor lock refused a direct write");

   property p_host_mapped_quiet;
      @(posedge core_clk) disable iff (rst)
      (req.wr && req.sel == SEL_PN && !guest_mode)
      |=> ($stable(guest_pn_out) && !wr_refused);
   endproperty
   a_host_mapped_quiet: assert property (p_host_mapped_quiet)
      else $error("host mode mapped write touched the guest number");

   property p_base_store;
      @(posedge core_clk) disable iff (rst)
      (req.wr && req.sel == SEL_GBASE)
      |=> (base_r == $past(req.wdata[31:9]) && dv_r == $past(req.wdata[1])
           && rh_r == $past(req.wdata[0]));
   endproperty
   a_base_store: assert property (p_base_store)
      else $error("handler base write not stored");
endmodule

// *** sim/gpihb_testbench.sv ***
// self-checking bench for the guest number, list and handler base block
`timescale 1ns/1ps
module testbench;
   import gpihb_pkg::*;
   logic        core_clk                 = 1'b0;
   logic        rst                      = 1'b1;
   logic        guest_mode               = 1'b0;
   logic        supervisor_lock_bit      = 1'b0;
   logic [31:0] host_allowed_number_list = 32'hFFFF_FFFF;
   gpihb_req_s  req                      = '0;
   gpihb_hreq_s hreq                     = '0;
   logic [31:0] rdata;
   logic        rd_valid;
   logic        wr_refused;
   logic [4:0]  guest_pn_out;
   logic        guest_base_select_bit;
   logic        hrsp_valid;
   logic [31:0] hrsp_addr;
   logic        hrsp_table;
   int          errors   = 0;
   int          n_checks = 0;

   always #5 core_clk = ~core_clk;

   gpihb_top dut (
      .core_clk                 (core_clk),
      .rst                      (rst),
      .guest_mode               (guest_mode),
      .supervisor_lock_bit      (supervisor_lock_bit),
      .host_allowed_number_list (host_allowed_number_list),
      .req                      (req),
      .hreq                     (hreq),
      .rdata                    (rdata),
      .rd_valid                 (rd_valid),
      .wr_refused               (wr_refused),
      .guest_pn_out             (guest_pn_out),
      .guest_base_select_bit    (guest_base_select_bit),
      .hrsp_valid               (hrsp_valid),
      .hrsp_addr                (hrsp_addr),
      .hrsp_table               (hrsp_table)
   );

   task automatic chk32(input string w, input logic [31:0] e,
                        input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic chk1(input string w, input logic e, input logic g);
      n_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %b seen %b", w, e, g);
      end
   endtask

   // an idle cycle follows each request so no field is driven twice at once
   task automatic wr(input logic [2:0] s, input logic [31:0] d,
                     input logic m, input logic ref_exp);
      req = '{wr: 1'b1, rd: 1'b0, multi: m, sel: s, wdata: d};
      @(negedge core_clk);
      chk1("wr_refused", ref_exp, wr_refused);
      req = '0;
      @(negedge core_clk);
   endtask

   task automatic rd(input logic [2:0] s, input logic [31:0] e);
      req = '{wr: 1'b0, rd: 1'b1, multi: 1'b0, sel: s, wdata: ZERO_W};
      @(negedge core_clk);
      chk1("rd_valid", 1'b1, rd_valid);
      chk32("rdata", e, rdata);
      req = '0;
      @(negedge core_clk);
   endtask

   task automatic hq(input logic ei, input logic tb, input logic [31:0] ea,
                     input logic et);
      hreq = '{valid: 1'b1, maskable_interrupt_request: ei, req_table: tb,
               offset: 32'h0000_0100, red_offset: 32'h0000_0010};
      @(negedge core_clk);
      chk1("hrsp_valid", 1'b1, hrsp_valid);
      chk32("hrsp_addr", ea, hrsp_addr);
      chk1("hrsp_table", et, hrsp_table);
      hreq = '0;
      @(negedge core_clk);
   endtask

   task automatic t_reset;
      rd(SEL_GPN, {27'h000_0000, PN_RST});
      rd(SEL_GLIST, LIST_RST);
      rd(SEL_GBASE, {BASE_RST, 7'h00, DV_RST, RH_RST});
      chk1("base_select", 1'b1, guest_base_select_bit);
      $display("test reset done");
   endtask

   task automatic t_direct;
      host_allowed_number_list = 32'h0000_0108;
      supervisor_lock_bit = 1'b1;
      wr(SEL_GPN, 32'hFFFF_FFE3, 1'b0, 1'b0);
      rd(SEL_GPN, 32'h0000_0003);
      chk32("guest_pn_out", 32'h3, {27'h0, guest_pn_out});
      wr(SEL_GPN, 32'h0000_0005, 1'b0, 1'b1);
      rd(SEL_GPN, 32'h0000_0003);
      wr(SEL_GPN, 32'h0000_0008, 1'b1, 1'b0);
      wr(SEL_GPN, 32'h0000_0009, 1'b1, 1'b1);
      chk32("guest_pn_out", 32'h8, {27'h0, guest_pn_out});
      guest_mode = 1'b1;
      wr(SEL_GPN, 32'h0000_0003, 1'b0, 1'b0);
      chk32("guest_pn_out", 32'h3, {27'h0, guest_pn_out});
      guest_mode = 1'b0;
      supervisor_lock_bit = 1'b0;
      $display("test direct done");
   endtask

   task automatic t_list;
      host_allowed_number_list = 32'hF0F0_00FF;
      wr(SEL_GLIST, 32'hFFFF_0F0F, 1'b0, 1'b0);
      rd(SEL_GLIST, 32'hF0F0_000F);
      guest_mode = 1'b1;
      wr(SEL_GLIST, 32'hFFFF_FFFF, 1'b0, 1'b1);
      wr(SEL_LIST, 32'hFFFF_FFFF, 1'b0, 1'b1);
      rd(SEL_LIST, 32'hF0F0_000F);
      guest_mode = 1'b0;
      rd(SEL_GLIST, 32'hF0F0_000F);
      $display("test list done");
   endtask

   task automatic t_mapped;
      // host list cleared: only the guest list and the lock may decide mapped writes
      host_allowed_number_list = 32'h0000_0000;
      guest_mode = 1'b1;
      wr(SEL_PN, 32'h0000_0002, 1'b0, 1'b0);
      wr(SEL_PN, 32'h0000_0004, 1'b0, 1'b1);
      wr(SEL_PN, 32'h0000_001F, 1'b1, 1'b0);
      supervisor_lock_bit = 1'b1;
      wr(SEL_PN, 32'h0000_0000, 1'b0, 1'b1);
      supervisor_lock_bit = 1'b0;
      rd(SEL_PN, 32'h0000_001F);
      chk1("base_select", 1'b1, guest_base_select_bit);
      guest_mode = 1'b0;
      wr(SEL_PN, 32'h0000_0000, 1'b0, 1'b0);
      chk32("guest_pn_out", 32'h1F, {27'h0, guest_pn_out});
      $display("test mapped done");
   endtask

   task automatic t_handler;
      wr(SEL_GBASE, 32'hABCD_E1FF, 1'b0, 1'b0);
      rd(SEL_GBASE, 32'hABCD_E003);
      hq(1'b1, 1'b1, 32'hABCD_E010, 1'b0);
      wr(SEL_GBASE, 32'hABCD_E002, 1'b0, 1'b0);
      hq(1'b1, 1'b1, 32'hABCD_E100, 1'b0);
      wr(SEL_GBASE, 32'hABCD_E001, 1'b0, 1'b0);
      hq(1'b1, 1'b1, 32'h0000_0000, 1'b1);
      hq(1'b1, 1'b0, 32'hABCD_E010, 1'b0);
      wr(SEL_GBASE, 32'hABCD_E000, 1'b0, 1'b0);
      hq(1'b1, 1'b0, 32'hABCD_E100, 1'b0);
      hq(1'b0, 1'b1, 32'hABCD_E100, 1'b0);
      $display("test handler done");
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // cuts a hang short; every wait below is a fixed, short count
   initial begin
      repeat (5000) @(posedge core_clk);
      errors++;
      $display("ERROR timeout expected finish seen hang");
      print_verdict();
   end

   initial begin
      repeat (4) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_reset();
      t_direct();
      t_list();
      t_mapped();
      t_handler();
      print_verdict();
   end
endmodule
